// *** include/dpc_regs.vh ***
// Register map, field layout and sizing constants of the defect corrector
`ifndef DPC_REGS_VH
`define DPC_REGS_VH
`define DPC_ADDR_W 8
`define DPC_OFS_COUNT 8'h00
`define DPC_OFS_INDEX 8'h04
`define DPC_OFS_COLUMN 8'h08
`define DPC_OFS_ROW 8'h0c
`define DPC_OFS_STORE 8'h10
`define DPC_OFS_CTRL 8'h14
`define DPC_OFS_STATUS 8'h18
`define DPC_PIX_W 12
`define DPC_COORD_W 12
`define DPC_ENTRY_W 4
`define DPC_CNT_W 5
`define DPC_DEPTH 16
`define DPC_MAX_COUNT 5'h10
`define DPC_CNT_RST 5'h00
`define DPC_IDX_RST 4'h0
`define DPC_COORD_RST 12'h000
`define DPC_CTRL_ENABLE 0
`define DPC_CTRL_COLOR 1
`define DPC_CTRL_RST 2'h1
`define DPC_ST_BUSY 0
`define DPC_ST_DONE 1
`define DPC_FIFO_DEPTH 8
`define DPC_FIFO_AW 3
`define DPC_ONE_COORD 12'h001
`define DPC_ONE_ENTRY 4'h1
`define DPC_ONE_CNT 5'h01
`define DPC_LAST_ENTRY 4'hf
`endif

// *** rtl/dpc_fifo.v ***
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dpc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire mclk_i, // Clock
   input wire reset_i, // Sync reset, high
   input wire ce_i, // Clock enable
   input wire in_valid_i, // Write request
   output wire in_ready_o, // Space available
   input wire [WIDTH-1:0] in_data_i, // Write data
   output wire out_valid_o, // Data available
   input wire out_ready_i, // Reader accepts
   output wire [WIDTH-1:0] out_data_o // Head word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] level;
   wire push;
   wire pop;
   assign in_ready_o = (level != DEPTH[AW:0]);
   assign out_valid_o = (level != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   always @(posedge mclk_i) begin
      if (reset_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         level <= {(AW+1){1'b0}};
      end else if (ce_i) begin
         if (push) begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         if (push && !pop)
            level <= level + {{AW{1'b0}}, 1'b1};
         else if (pop && !push)
            level <= level - {{AW{1'b0}}, 1'b1};
      end
   end
endmodule // dpc_fifo
`default_nettype wire

// *** rtl/dpc_table.v ***
// Defect coordinate table: one column and row per entry, registered read
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.vh"
module dpc_table (
   input wire mclk_i, // Clock
   input wire reset_i, // Sync reset, high
   input wire ce_i, // Clock enable
   input wire [`DPC_ENTRY_W-1:0] wr_idx_i, // Entry written
   input wire wr_col_i, // Write column
   input wire wr_row_i, // Write row
   input wire [`DPC_COORD_W-1:0] wr_data_i, // Coordinate data
   input wire [`DPC_ENTRY_W-1:0] rd_idx_i, // Entry read
   output reg [`DPC_COORD_W-1:0] rd_col_o, // Registered column
   output reg [`DPC_COORD_W-1:0] rd_row_o // Registered row
);
   reg [`DPC_COORD_W-1:0] col_mem [0:`DPC_DEPTH-1];
   reg [`DPC_COORD_W-1:0] row_mem [0:`DPC_DEPTH-1];
   always @(posedge mclk_i) begin
      if (ce_i) begin
         if (wr_col_i)
            col_mem[wr_idx_i] <= wr_data_i;
         if (wr_row_i)
            row_mem[wr_idx_i] <= wr_data_i;
      end
   end
   always @(posedge mclk_i) begin
      if (reset_i) begin
         rd_col_o <= `DPC_COORD_RST;
         rd_row_o <= `DPC_COORD_RST;
      end else if (ce_i) begin
         rd_col_o <= col_mem[rd_idx_i];
         rd_row_o <= row_mem[rd_idx_i];
      end
   end
endmodule // dpc_table
`default_nettype wire

// *** rtl/dpc_top.v ***
// Defective pixel corrector: APB registers, coordinate table, stream path
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.vh"
module dpc_top (
   input wire mclk_i, // 100 MHz clock
   input wire reset_i, // Sync reset, high
   input wire ce_i, // Clock enable, freezes all
   input wire psel_i, // APB select
   input wire penable_i, // APB enable
   input wire pwrite_i, // APB direction
   input wire [`DPC_ADDR_W-1:0] paddr_i, // APB byte address
   input wire [31:0] pwdata_i, // APB write data
   output wire pready_o, // APB ready
   output reg [31:0] prdata_o, // APB read data
   output wire pslverr_o, // APB error, unmapped
   input wire s_valid_i, // Input pixel valid
   output wire s_ready_o, // Input pixel accepted
   input wire [`DPC_PIX_W-1:0] s_data_i, // Input pixel value
   input wire s_sof_i, // First pixel of frame
   input wire s_eol_i, // Last pixel of line
   output wire m_valid_o, // Output pixel valid
   input wire m_ready_i, // Downstream ready
   output wire [`DPC_PIX_W-1:0] m_data_o, // Corrected pixel
   output reg nvm_req_o, // Store transfer active
   output reg [`DPC_ENTRY_W-1:0] nvm_addr_o, // Stored entry index
   output reg [31:0] nvm_data_o, // Count, then column/row
   output reg nvm_count_o, // Word carries the count
   input wire nvm_ack_i // Memory took the word
);
   reg [`DPC_CNT_W-1:0] defect_entry_count;
   reg [`DPC_ENTRY_W-1:0] defect_entry_index;
   reg [1:0] ctrl;
   reg done;
   reg [1:0] st_state;
   reg [`DPC_ENTRY_W-1:0] st_idx;
   reg [`DPC_COORD_W-1:0] x_cnt;
   reg [`DPC_COORD_W-1:0] y_cnt;
   reg hold_vld;
   reg [`DPC_PIX_W-1:0] hold_pix;
   reg hold_bad;
   reg mid_vld;
   reg [`DPC_PIX_W-1:0] mid_pix;
   reg mid_bad;
   integer k;
   reg hit;
   reg [`DPC_PIX_W-1:0] next_out;
   wire [`DPC_COORD_W-1:0] defect_column;
   wire [`DPC_COORD_W-1:0] defect_row;
   wire wr_en;
   wire rd_en;
   wire busy;
   wire take;
   wire push;
   wire f_ready;
   wire f_valid;
   wire [`DPC_COORD_W-1:0] cur_x;
   wire [`DPC_COORD_W-1:0] cur_y;
   wire [`DPC_ENTRY_W-1:0] tbl_rd_idx;
   reg [`DPC_COORD_W-1:0] lut_col [0:`DPC_DEPTH-1];
   reg [`DPC_COORD_W-1:0] lut_row [0:`DPC_DEPTH-1];

   localparam ST_IDLE = 2'h0;
   localparam ST_COUNT = 2'h1;
   localparam ST_FETCH = 2'h2;
   localparam ST_ENTRY = 2'h3;

   // A frozen block stalls the bus rather than dropping a write
   assign pready_o = ce_i;
   assign wr_en = psel_i & penable_i & pwrite_i & ce_i;
   assign rd_en = psel_i & penable_i & ~pwrite_i;
   assign pslverr_o = psel_i & penable_i &
      (paddr_i > `DPC_OFS_STATUS || paddr_i[1:0] != 2'b00);
   assign busy = (st_state != ST_IDLE);

   // Store walk reads the table; otherwise the selected entry is shown
   assign tbl_rd_idx = busy ? st_idx : defect_entry_index;

   dpc_table u_table (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .wr_idx_i(defect_entry_index),
      .wr_col_i(wr_en && paddr_i == `DPC_OFS_COLUMN),
      .wr_row_i(wr_en && paddr_i == `DPC_OFS_ROW),
      .wr_data_i(pwdata_i[`DPC_COORD_W-1:0]),
      .rd_idx_i(tbl_rd_idx),
      .rd_col_o(defect_column),
      .rd_row_o(defect_row)
   );

   // Shadow copy for the stream compare; the table read port is one entry
   always @(posedge mclk_i) begin
      if (wr_en && paddr_i == `DPC_OFS_COLUMN)
         lut_col[defect_entry_index] <= pwdata_i[`DPC_COORD_W-1:0];
      if (wr_en && paddr_i == `DPC_OFS_ROW)
         lut_row[defect_entry_index] <= pwdata_i[`DPC_COORD_W-1:0];
   end

   always @(posedge mclk_i) begin
      if (reset_i) begin
         defect_entry_count <= `DPC_CNT_RST;
         defect_entry_index <= `DPC_IDX_RST;
         ctrl <= `DPC_CTRL_RST;
      end else if (wr_en) begin
         case (paddr_i)
            `DPC_OFS_COUNT: begin
               // Clamped so the count never names entries that do not exist
               if (pwdata_i[`DPC_CNT_W-1:0] > `DPC_MAX_COUNT)
                  defect_entry_count <= `DPC_MAX_COUNT;
               else
                  defect_entry_count <= pwdata_i[`DPC_CNT_W-1:0];
            end
            `DPC_OFS_INDEX:
               defect_entry_index <= pwdata_i[`DPC_ENTRY_W-1:0];
            `DPC_OFS_CTRL:
               ctrl <= pwdata_i[1:0];
            default: ;
         endcase
      end
   end

   always @* begin
      prdata_o = 32'h0000_0000;
      if (rd_en) begin
         case (paddr_i)
            `DPC_OFS_COUNT:
               prdata_o[`DPC_CNT_W-1:0] = defect_entry_count;
            `DPC_OFS_INDEX:
               prdata_o[`DPC_ENTRY_W-1:0] = defect_entry_index;
            `DPC_OFS_COLUMN:
               prdata_o[`DPC_COORD_W-1:0] = defect_column;
            `DPC_OFS_ROW:
               prdata_o[`DPC_COORD_W-1:0] = defect_row;
            `DPC_OFS_CTRL:
               prdata_o[1:0] = ctrl;
            `DPC_OFS_STATUS: begin
               prdata_o[`DPC_ST_BUSY] = busy;
               prdata_o[`DPC_ST_DONE] = done;
            end
            default: ;
         endcase
      end
   end

   // Store sequencer: count word first, then every entry in index order
   always @(posedge mclk_i) begin
      if (reset_i) begin
         st_state <= ST_IDLE;
         st_idx <= `DPC_IDX_RST;
         done <= 1'b0;
         nvm_req_o <= 1'b0;
         nvm_addr_o <= `DPC_IDX_RST;
         nvm_data_o <= 32'h0000_0000;
         nvm_count_o <= 1'b0;
      end else if (ce_i) begin
         case (st_state)
            ST_IDLE: begin
               if (wr_en && paddr_i == `DPC_OFS_STORE && pwdata_i[0]) begin
                  st_state <= ST_COUNT;
                  st_idx <= `DPC_IDX_RST;
                  done <= 1'b0;
                  nvm_req_o <= 1'b1;
                  nvm_count_o <= 1'b1;
                  nvm_addr_o <= `DPC_IDX_RST;
                  nvm_data_o <= {{(32-`DPC_CNT_W){1'b0}}, defect_entry_count};
               end
            end
            ST_COUNT: begin
               // The word stands until the memory acknowledges it
               if (nvm_ack_i) begin
                  nvm_req_o <= 1'b0;
                  nvm_count_o <= 1'b0;
                  st_state <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               // One cycle for the registered table read to settle
               st_state <= ST_ENTRY;
            end
            ST_ENTRY: begin
               if (!nvm_req_o) begin
                  nvm_req_o <= 1'b1;
                  nvm_addr_o <= st_idx;
                  nvm_data_o <= {4'h0, defect_row, 4'h0, defect_column};
               end else if (nvm_ack_i) begin
                  nvm_req_o <= 1'b0;
                  if (st_idx == `DPC_LAST_ENTRY) begin
                     st_state <= ST_IDLE;
                     done <= 1'b1;
                  end else begin
                     st_idx <= st_idx + `DPC_ONE_ENTRY;
                     st_state <= ST_FETCH;
                  end
               end
            end
            default: st_state <= ST_IDLE;
         endcase
      end
   end

   // Stream position counters, both from zero
   assign take = s_valid_i & s_ready_o;
   assign cur_x = s_sof_i ? `DPC_COORD_RST : x_cnt;
   assign cur_y = s_sof_i ? `DPC_COORD_RST : y_cnt;

   always @(posedge mclk_i) begin
      if (reset_i) begin
         x_cnt <= `DPC_COORD_RST;
         y_cnt <= `DPC_COORD_RST;
      end else if (ce_i && take) begin
         if (s_eol_i) begin
            x_cnt <= `DPC_COORD_RST;
            y_cnt <= cur_y + `DPC_ONE_COORD;
         end else begin
            x_cnt <= cur_x + `DPC_ONE_COORD;
            y_cnt <= cur_y;
         end
      end
   end

   // Unrolls into one comparator pair per entry, all in parallel
   always @* begin
      hit = 1'b0;
      for (k = 0; k < `DPC_DEPTH; k = k + 1) begin
         if (k[`DPC_CNT_W-1:0] < defect_entry_count &&
             lut_col[k[`DPC_ENTRY_W-1:0]] == cur_x &&
             lut_row[k[`DPC_ENTRY_W-1:0]] == cur_y)
            hit = 1'b1;
      end
   end

   // A pixel is held back two places, so both substitutes are at hand when
   // it leaves: the following pixel (mono) or the one after it (colour).
   // Limitation: near a line end the substitute comes from the next line,
   // and the last two pixels of a stream wait for further input.
   assign push = take;
   // Handshakes drop while frozen, so no pixel is lost or doubled
   assign s_ready_o = f_ready & ce_i;
   assign m_valid_o = f_valid & ce_i;

   always @* begin
      next_out = hold_pix;
      if (hold_bad && ctrl[`DPC_CTRL_ENABLE]) begin
         if (ctrl[`DPC_CTRL_COLOR])
            next_out = s_data_i;
         else
            next_out = mid_pix;
      end
   end

   always @(posedge mclk_i) begin
      if (reset_i) begin
         mid_vld <= 1'b0;
         mid_pix <= `DPC_COORD_RST;
         mid_bad <= 1'b0;
         hold_vld <= 1'b0;
         hold_pix <= `DPC_COORD_RST;
         hold_bad <= 1'b0;
      end else if (ce_i && take) begin
         // Mid holds pixel p+1, hold holds pixel p
         mid_vld <= 1'b1;
         mid_pix <= s_data_i;
         mid_bad <= hit;
         hold_vld <= mid_vld;
         hold_pix <= mid_pix;
         hold_bad <= mid_bad;
      end
   end

   dpc_fifo #(
      .WIDTH(`DPC_PIX_W),
      .DEPTH(`DPC_FIFO_DEPTH),
      .AW(`DPC_FIFO_AW)
   ) u_fifo (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .in_valid_i(push & hold_vld),
      .in_ready_o(f_ready),
      .in_data_i(next_out),
      .out_valid_o(f_valid),
      .out_ready_i(m_ready_i),
      .out_data_o(m_data_o)
   );
endmodule // dpc_top
`default_nettype wire

// *** test/dpc_nvm_model.sv ***
// Non-volatile memory partner taking store words after a random delay
`timescale 1ns/1ns
`default_nettype none
module dpc_nvm_model (
   input wire logic mclk_i, // Clock
   input wire logic reset_i, // Sync reset, high
   input wire logic req_i, // Word offered
   input wire logic [3:0] addr_i, // Entry index
   input wire logic [31:0] data_i, // Offered word
   input wire logic count_i, // Word is the count
   output logic ack_o // Word taken
);
   logic [31:0] mem [0:15];
   logic [31:0] cnt_word;
   logic [1:0] wt;
   always @(posedge mclk_i) begin
      if (reset_i) begin
         ack_o <= 1'b0;
         wt <= 2'h0;
      end else if (ack_o) begin
         ack_o <= 1'b0;
         if (count_i)
            cnt_word <= data_i;
         else
            mem[addr_i] <= data_i;
      end else if (req_i) begin
         // Random wait so both prompt and slow answers occur
         if (wt == 2'h0)
            ack_o <= 1'b1;
         wt <= (wt == 2'h0) ? 2'($urandom) : wt - 2'h1;
      end
   end
endmodule // dpc_nvm_model
`default_nettype wire

// *** test/dpc_top_assertions.sv ***
// Port-level checks of the defect corrector
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.vh"
module dpc_top_assertions (
   input wire logic mclk_i, // Clock
   input wire logic reset_i, // Sync reset
   input wire logic ce_i, // Clock enable
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic [`DPC_ADDR_W-1:0] paddr_i, // APB address
   input wire logic [31:0] prdata_o, // APB read data
   input wire logic pslverr_o, // APB error
   input wire logic m_valid_o, // Output valid
   input wire logic m_ready_i, // Output ready
   input wire logic [`DPC_PIX_W-1:0] m_data_o, // Output pixel
   input wire logic nvm_req_o, // Store word offered
   input wire logic [`DPC_ENTRY_W-1:0] nvm_addr_o, // Store index
   input wire logic [31:0] nvm_data_o, // Store word
   input wire logic nvm_count_o, // Word is count
   input wire logic nvm_ack_i // Word taken
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   sequence s_access;
      psel_i && penable_i;
   endsequence
   sequence s_count_taken;
      nvm_req_o && nvm_count_o && nvm_ack_i;
   endsequence
   sequence s_first_entry;
      nvm_req_o && !nvm_count_o && nvm_addr_o == 4'h0;
   endsequence
   a_err_unmapped: assert property (
      s_access ##0 paddr_i > 8'h18 |-> pslverr_o)
      else $error("unmapped access not flagged");
   a_err_mapped: assert property (
      s_access ##0 (paddr_i <= 8'h18 && paddr_i[1:0] == 2'h0) |-> !pslverr_o)
      else $error("mapped access flagged");
   a_rdata_quiet: assert property (
      !(psel_i && penable_i) |-> prdata_o == 32'h0)
      else $error("read data outside access");
   a_nvm_holds: assert property (
      nvm_req_o && !nvm_ack_i |=>
      nvm_req_o && $stable(nvm_data_o) && $stable(nvm_addr_o))
      else $error("store word dropped before ack");
   a_count_word: assert property (
      nvm_req_o && nvm_count_o |-> nvm_data_o <= 32'h10)
      else $error("stored count above depth");
   a_entry_fields: assert property (
      nvm_req_o && !nvm_count_o |->
      nvm_data_o[31:28] == 4'h0 && nvm_data_o[15:12] == 4'h0)
      else $error("stored entry layout wrong");
   a_first_entry: assert property (
      s_count_taken |-> ##[1:6] s_first_entry)
      else $error("entry 0 not stored after count");
   a_out_hold: assert property (
      (m_valid_o && !m_ready_i) ##1 ce_i |-> m_valid_o && $stable(m_data_o))
      else $error("output pixel changed while stalled");
endmodule // dpc_top_assertions
bind dpc_top dpc_top_assertions u_dpc_top_assertions (.mclk_i(mclk_i),
   .reset_i(reset_i), .ce_i(ce_i), .psel_i(psel_i),
   .penable_i(penable_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
   .m_valid_o(m_valid_o), .m_ready_i(m_ready_i), .m_data_o(m_data_o),
   .nvm_req_o(nvm_req_o), .nvm_addr_o(nvm_addr_o),
   .nvm_data_o(nvm_data_o), .nvm_count_o(nvm_count_o),
   .nvm_ack_i(nvm_ack_i));
`default_nettype wire

// *** test/dpc_top_tb.sv ***
// Self-checking bench of the defect corrector
`timescale 1ns/1ns
`default_nettype none
module dpc_top_tb;
   localparam W = 8;
   localparam H = 5;
   logic mclk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, rd, nvm_data_o;
   logic pready_o, pslverr_o, er, s_valid_i = 0, s_ready_o, s_sof_i = 0;
   logic s_eol_i = 0, m_valid_o, m_ready_i = 0, hold = 1;
   logic ce_i = 1, ce_rand = 0;
   logic nvm_req_o, nvm_count_o, nvm_ack_i;
   logic [11:0] s_data_i = 0, m_data_o, ep, pix [0:2*W*H+1];
   logic [11:0] tcol [0:15], trow [0:15], expq [$];
   logic [3:0] nvm_addr_o;
   int n_mismatch = 0, checks = 0, k, n, n_out = 0;
   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) ce_i <= !ce_rand || $urandom % 8 != 0;
   dpc_top u_dpc_top (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .s_valid_i(s_valid_i),
      .s_ready_o(s_ready_o), .s_data_i(s_data_i), .s_sof_i(s_sof_i),
      .s_eol_i(s_eol_i), .m_valid_o(m_valid_o), .m_ready_i(m_ready_i),
      .m_data_o(m_data_o), .nvm_req_o(nvm_req_o), .nvm_addr_o(nvm_addr_o),
      .nvm_data_o(nvm_data_o), .nvm_count_o(nvm_count_o),
      .nvm_ack_i(nvm_ack_i));
   dpc_nvm_model u_dpc_nvm_model (.mclk_i(mclk_i), .reset_i(reset_i),
      .req_i(nvm_req_o), .addr_i(nvm_addr_o), .data_i(nvm_data_o),
      .count_i(nvm_count_o), .ack_o(nvm_ack_i));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task results;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      for (t = 0; t < 20; t++) begin
         @(posedge mclk_i);
         if (pready_o === 1'b1) break;
      end
      if (t == 20) begin
         chk("pready", 1, 0);
         results;
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 0);
      chk(nm, e, rd);
   endtask
   task send(input int p);
      int t;
      s_valid_i <= 1'b1;
      s_data_i <= pix[p];
      s_sof_i <= p % (W * H) == 0;
      s_eol_i <= p % W == W - 1;
      for (t = 0; t < 50; t++) begin
         @(posedge mclk_i);
         if (s_ready_o === 1'b1) break;
      end
      if (t == 50) begin
         chk("s_ready", 1, 0);
         results;
      end
      if ($urandom % 2) begin
         s_valid_i <= 1'b0;
         @(posedge mclk_i);
      end
   endtask
   // Substitute is the next pixel (mono) or the one after (colour)
   function automatic logic [11:0] expect_pix(int p, bit colour);
      for (int j = 0; j < 4; j++)
         if (tcol[j] == p % W && trow[j] == (p / W) % H)
            return colour ? pix[p + 2] : pix[p + 1];
      return pix[p];
   endfunction
   always @(posedge mclk_i) begin
      m_ready_i <= !hold && $urandom % 4 != 0;
      if (m_valid_o === 1'b1 && m_ready_i === 1'b1) begin
         if (expq.size() == 0)
            chk("extra pixel", 0, 1);
         else begin
            ep = expq.pop_front();
            if (n_out >= W * H)
               chk("colour pixel", 32'(ep), 32'(m_data_o));
            else
               chk("pixel", 32'(ep), 32'(m_data_o));
            n_out++;
         end
      end
   end
   initial begin
      k = $urandom(32'h436d368e);
      for (k = 0; k < 16; k++) {tcol[k], trow[k]} = 0;
      for (k = 0; k <= 2 * W * H + 1; k++) pix[k] = 12'($urandom);
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      rdc("count", 8'h00, 0);
      rdc("index", 8'h04, 0);
      rdc("ctrl", 8'h14, 1);
      rdc("unmapped", 8'h1c, 0);
      chk("pslverr", 1, 32'(er));
      apb(1'b1, 8'h00, 32'h1f);
      rdc("count clamp", 8'h00, 32'h10);
      for (k = 0; k < 16; k++) begin
         if (k < 5) begin
            tcol[k] = 12'(k == 0 ? 0 : k == 3 ? W - 2 : $urandom % (W - 1));
            trow[k] = 12'(k);
         end
         if (k < 4) apb(1'b1, 8'h00, k + 1);
         apb(1'b1, 8'h04, k);
         apb(1'b1, 8'h08, 32'(tcol[k]));
         apb(1'b1, 8'h0c, 32'(trow[k]));
         rdc("column", 8'h08, 32'(tcol[k]));
         rdc("row", 8'h0c, 32'(trow[k]));
      end
      apb(1'b1, 8'h04, 2);
      rdc("column back", 8'h08, 32'(tcol[2]));
      rdc("count", 8'h00, 4);
      apb(1'b1, 8'h10, 1);
      for (n = 0; n < 500; n++) begin
         apb(1'b0, 8'h18, 0);
         if (rd[1] === 1'b1) break;
      end
      chk("store done", 1, 32'(n < 500));
      chk("stored count", 4, u_dpc_nvm_model.cnt_word);
      for (k = 0; k < 16; k++)
         chk("stored entry", {4'h0, trow[k], 4'h0, tcol[k]},
            u_dpc_nvm_model.mem[k]);
      for (k = 0; k < W * H; k++) expq.push_back(expect_pix(k, 0));
      // Downstream stalled: ten pixels fill the delay line and FIFO
      for (k = 0; k < 10; k++) send(k);
      s_valid_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk("s_ready full", 0, 32'(s_ready_o));
      hold <= 1'b0;
      fork
         begin
            for (k = 10; k <= W * H + 1; k++) send(k);
            s_valid_i <= 1'b0;
         end
         for (n = 0; n < 3000 && expq.size() > 0; n++) @(posedge mclk_i);
      join
      repeat (3) @(posedge mclk_i);
      chk("pixels left", 0, expq.size());
      // Colour frame, clock enable dropping at random
      apb(1'b1, 8'h14, 3);
      rdc("ctrl colour", 8'h14, 3);
      ce_rand <= 1'b1;
      for (k = W * H; k < 2 * W * H; k++)
         expq.push_back(expect_pix(k, 1));
      fork
         begin
            for (k = W * H + 2; k <= 2 * W * H + 1; k++) send(k);
            s_valid_i <= 1'b0;
         end
         for (n = 0; n < 3000 && expq.size() > 0; n++) @(posedge mclk_i);
      join
      ce_rand <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chk("colour pixels left", 0, expq.size());
      chk("m_valid idle", 0, 32'(m_valid_o));
      results;
   end
endmodule // dpc_top_tb
`default_nettype wire
